// ### apfs_pkg.sv
package apfs_pkg;

	// ==========================================
	// clock and timing
	localparam int unsigned CLOCK_HZ = 25_000_000;
	localparam int unsigned LED_HOLD_MS = 10;
	localparam int unsigned LED_HOLD_CYCLES = (CLOCK_HZ / 1000) * LED_HOLD_MS;

	// ==========================================
	// pin banks
	localparam int unsigned AUX_PINS = 10;
	localparam int unsigned PULLDOWN_PIN = 7;
	localparam logic [9:0] GENERAL_PINS = 10'h37f;
	localparam logic [9:0] CLOCK_PINS = 10'h361;
	localparam logic [9:0] BITBANG_PINS = 10'h360;

	// ==========================================
	// register offsets
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] ADDR_FUNC_LO = 12'h000;
	localparam logic [11:0] ADDR_FUNC_HI = 12'h004;
	localparam logic [11:0] ADDR_CTRL = 12'h008;
	localparam logic [11:0] ADDR_BITBANG = 12'h00c;
	localparam logic [11:0] ADDR_STATUS = 12'h010;

	// ==========================================
	// fields
	localparam int unsigned FUNC_W = 4;
	localparam int unsigned CTRL_APPLY_BIT = 0;
	localparam int unsigned CTRL_WAKE_BIT = 1;
	localparam int unsigned CTRL_SUSP_PD_BIT = 2;
	localparam int unsigned CTRL_MODE_BIT = 3;
	localparam int unsigned BB_DATA_LSB = 0;
	localparam int unsigned BB_DIR_LSB = 16;
	localparam int unsigned ST_APPLIED_BIT = 0;
	localparam int unsigned ST_SUSPEND_BIT = 1;
	localparam int unsigned ST_CONFIGURED_BIT = 2;
	localparam int unsigned ST_TX_BUSY_BIT = 3;
	localparam int unsigned ST_IN_LSB = 16;

	// ==========================================
	// reset values
	localparam logic [31:0] FUNC_LO_RESET = 32'hd9999999;
	localparam logic [31:0] FUNC_HI_RESET = 32'h00000099;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] BITBANG_RESET = 32'h00000000;

	// ==========================================
	// types
	typedef enum logic [3:0] {
		FN_TX_DRIVER_ENABLE = 4'h0,
		FN_POWER_SWITCH = 4'h1,
		FN_TX_LED = 4'h2,
		FN_RX_LED = 4'h3,
		FN_TXRX_LED = 4'h4,
		FN_SLEEP = 4'h5,
		FN_CLOCK_DIV2 = 4'h6,
		FN_CLOCK_DIV4 = 4'h7,
		FN_CLOCK_DIV8 = 4'h8,
		FN_INPUT_PULLUP = 4'h9,
		FN_DRIVE_HIGH = 4'ha,
		FN_DRIVE_LOW = 4'hb,
		FN_BITBANG = 4'hc,
		FN_INPUT_PULLDOWN = 4'hd
	} apfs_func_t;

	typedef struct packed {
		logic txd;
		logic rts_n;
		logic dtr_n;
	} apfs_uart_out_t;

	typedef struct packed {
		logic rxd;
		logic cts_n;
		logic dsr_n;
		logic carrier_detect_n;
		logic ring_indicate_n;
	} apfs_uart_in_t;

endpackage

// ### apfs_activity_stretch.sv
`timescale 1ns/100ps
module apfs_activity_stretch #(
	parameter int unsigned HOLD = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// activity in, led out
	input wire logic active,
	output logic led_n
);

	localparam int unsigned CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD);

	logic [CW-1:0] hold_count;

	// short bursts would not be visible, so keep the led lit for a while
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hold_count <= '0;
		end else if (active) begin
			hold_count <= HOLD_LOAD;
		end else if (hold_count != '0) begin
			hold_count <= hold_count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			led_n <= 1'b1;
		end else begin
			led_n <= ~(active | (hold_count != '0));
		end
	end

endmodule // apfs_activity_stretch

// ### apfs_clock_divider.sv
`timescale 1ns/100ps
module apfs_clock_divider (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// control
	input wire logic stop,
	// divided outputs
	output logic div2,
	output logic div4,
	output logic div8
);

	logic [2:0] count;

	// stopping resets the phase so outputs restart cleanly low
	always_ff @(posedge clock) begin
		if (sys_rst || stop) begin
			count <= 3'h0;
		end else begin
			count <= count + 3'h1;
		end
	end

	assign div2 = count[0];
	assign div4 = count[1];
	assign div8 = count[2];

endmodule // apfs_clock_divider

// ### apfs_aux_pin_function_select.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
module apfs_aux_pin_function_select #(
	parameter int unsigned AUX_PINS = apfs_pkg::AUX_PINS,
	parameter int unsigned LED_HOLD_CYCLES = apfs_pkg::LED_HOLD_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// usb core status
	input wire logic usb_configured,
	input wire logic usb_suspend,
	output logic resume_request,
	// configuration memory strap
	input wire logic config_memory_present,
	// uart engine side
	input wire apfs_pkg::apfs_uart_out_t uart_out,
	output apfs_pkg::apfs_uart_in_t uart_in,
	input wire logic tx_request,
	input wire logic bit_tick,
	input wire logic tx_active,
	input wire logic tx_done,
	input wire logic rx_active,
	output logic tx_go,
	// primary pin bank
	output apfs_pkg::apfs_uart_out_t primary_pin_out,
	output logic primary_pin_oe,
	input wire apfs_pkg::apfs_uart_in_t primary_pin_in,
	output logic serial_pullup,
	output logic serial_pulldown,
	// aux pin bank
	input wire logic [AUX_PINS-1:0] aux_pin_in,
	output logic [AUX_PINS-1:0] aux_pin_out,
	output logic [AUX_PINS-1:0] aux_pin_oe,
	output logic [AUX_PINS-1:0] aux_pullup,
	output logic [AUX_PINS-1:0] aux_pulldown
);

	// ==========================================
	// functions

	function automatic logic code_allowed(input int unsigned pin, input logic [3:0] code);
		logic ok;
		ok = 1'b0;
		case (code)
			apfs_pkg::FN_CLOCK_DIV2, apfs_pkg::FN_CLOCK_DIV4,
			apfs_pkg::FN_CLOCK_DIV8, apfs_pkg::FN_DRIVE_HIGH: ok = apfs_pkg::CLOCK_PINS[pin];
			apfs_pkg::FN_BITBANG: ok = apfs_pkg::BITBANG_PINS[pin];
			apfs_pkg::FN_INPUT_PULLDOWN: ok = (pin == apfs_pkg::PULLDOWN_PIN);
			apfs_pkg::FN_INPUT_PULLUP: ok = 1'b1;
			apfs_pkg::FN_TX_DRIVER_ENABLE, apfs_pkg::FN_POWER_SWITCH,
			apfs_pkg::FN_TX_LED, apfs_pkg::FN_RX_LED, apfs_pkg::FN_TXRX_LED,
			apfs_pkg::FN_SLEEP, apfs_pkg::FN_DRIVE_LOW: ok = apfs_pkg::GENERAL_PINS[pin];
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] target);
		return addr == target;
	endfunction

	// ==========================================
	// input synchronisers

	logic [AUX_PINS-1:0] aux_meta;
	logic [AUX_PINS-1:0] aux_sync;
	apfs_pkg::apfs_uart_in_t prim_meta;
	apfs_pkg::apfs_uart_in_t prim_sync;
	logic strap_meta;
	logic strap_sync;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aux_meta <= '0;
			aux_sync <= '0;
			prim_meta <= '1;
			prim_sync <= '1;
		end else begin
			aux_meta <= aux_pin_in;
			aux_sync <= aux_meta;
			prim_meta <= primary_pin_in;
			prim_sync <= prim_meta;
		end
	end

	// strap runs through reset so the load decision sees a settled level;
	// reset must therefore last at least two clocks
	always_ff @(posedge clock) begin
		strap_meta <= config_memory_present;
		strap_sync <= strap_meta;
	end

	// ==========================================
	// registers

	logic [31:0] func_lo;
	logic [31:0] func_hi;
	logic [31:0] ctrl;
	logic [31:0] bitbang;
	logic [31:0] status_word;
	logic [31:0] next_prdata;
	logic mapped;
	logic wr_access;
	logic applied;
	logic [2:0] tx_state_code;

	always_comb begin
		mapped = 1'b0;
		next_prdata = 32'h0;
		if (addr_is(paddr, apfs_pkg::ADDR_FUNC_LO)) begin
			mapped = 1'b1;
			next_prdata = func_lo;
		end else if (addr_is(paddr, apfs_pkg::ADDR_FUNC_HI)) begin
			mapped = 1'b1;
			next_prdata = func_hi;
		end else if (addr_is(paddr, apfs_pkg::ADDR_CTRL)) begin
			mapped = 1'b1;
			next_prdata = ctrl;
		end else if (addr_is(paddr, apfs_pkg::ADDR_BITBANG)) begin
			mapped = 1'b1;
			next_prdata = bitbang;
		end else if (addr_is(paddr, apfs_pkg::ADDR_STATUS)) begin
			mapped = 1'b1;
			next_prdata = status_word;
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[apfs_pkg::ST_APPLIED_BIT] = applied;
		status_word[apfs_pkg::ST_SUSPEND_BIT] = usb_suspend;
		status_word[apfs_pkg::ST_CONFIGURED_BIT] = usb_configured;
		status_word[apfs_pkg::ST_TX_BUSY_BIT] = tx_state_code != 3'h0;
		status_word[apfs_pkg::ST_IN_LSB +: AUX_PINS] = aux_sync;
	end

	// zero wait states: data is latched in setup, answered in access
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_access = psel & penable & pwrite & mapped;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			func_lo <= apfs_pkg::FUNC_LO_RESET;
			func_hi <= apfs_pkg::FUNC_HI_RESET;
		end else if (wr_access) begin
			if (addr_is(paddr, apfs_pkg::ADDR_FUNC_LO)) begin
				func_lo <= pwdata;
			end else if (addr_is(paddr, apfs_pkg::ADDR_FUNC_HI)) begin
				func_hi <= {24'h0, pwdata[7:0]};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl <= apfs_pkg::CTRL_RESET;
		end else if (wr_access && addr_is(paddr, apfs_pkg::ADDR_CTRL)) begin
			ctrl <= {28'h0, pwdata[3:0]};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bitbang <= apfs_pkg::BITBANG_RESET;
		end else if (wr_access && addr_is(paddr, apfs_pkg::ADDR_BITBANG)) begin
			bitbang <= {6'h0, pwdata[25:16], 6'h0, pwdata[9:0]};
		end
	end

	// ==========================================
	// configuration load

	typedef enum logic [1:0] {
		CFG_LOAD = 2'b00,
		CFG_WAIT = 2'b01,
		CFG_RUN = 2'b10
	} apfs_cfg_state_t;

	apfs_cfg_state_t cfg_state;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_state <= CFG_LOAD;
		end else begin
			case (cfg_state)
				CFG_LOAD: begin
					cfg_state <= strap_sync ? CFG_WAIT : CFG_RUN;
				end
				CFG_WAIT: begin
					if (ctrl[apfs_pkg::CTRL_APPLY_BIT]) begin
						cfg_state <= CFG_RUN;
					end
				end
				CFG_RUN: begin
					cfg_state <= CFG_RUN;
				end
				default: begin
					cfg_state <= CFG_LOAD;
				end
			endcase
		end
	end

	assign applied = cfg_state == CFG_RUN;

	// ==========================================
	// rs485 driver enable sequencing

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_ALIGN = 3'b001,
		TX_LEAD = 3'b010,
		TX_SEND = 3'b011
	} apfs_tx_state_t;

	apfs_tx_state_t tx_state;
	logic tx_den;

	// lead by one bit, hold to stop end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_state <= TX_IDLE;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_request) begin
						tx_state <= TX_ALIGN;
					end
				end
				// enable rises on a tick, so its lead is a whole bit, never a fraction
				TX_ALIGN: begin
					if (bit_tick) begin
						tx_state <= TX_LEAD;
					end
				end
				TX_LEAD: begin
					if (bit_tick) begin
						tx_state <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_done) begin
						tx_state <= TX_IDLE;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	assign tx_state_code = tx_state;
	assign tx_go = (tx_state == TX_LEAD) & bit_tick;
	assign tx_den = (tx_state == TX_LEAD) | (tx_state == TX_SEND);

	// ==========================================
	// status-derived pin functions

	logic power_switch_n;
	logic sleep_n;
	logic tx_led_n;
	logic rx_led_n;
	logic txrx_led_n;
	logic clk_div2;
	logic clk_div4;
	logic clk_div8;

	assign power_switch_n = ~(usb_configured & ~usb_suspend);
	assign sleep_n = ~usb_suspend;

	apfs_activity_stretch #(.HOLD(LED_HOLD_CYCLES)) u_tx_led (
		.clock(clock),
		.sys_rst(sys_rst),
		.active(tx_active),
		.led_n(tx_led_n)
	);

	apfs_activity_stretch #(.HOLD(LED_HOLD_CYCLES)) u_rx_led (
		.clock(clock),
		.sys_rst(sys_rst),
		.active(rx_active),
		.led_n(rx_led_n)
	);

	apfs_activity_stretch #(.HOLD(LED_HOLD_CYCLES)) u_txrx_led (
		.clock(clock),
		.sys_rst(sys_rst),
		.active(tx_active | rx_active),
		.led_n(txrx_led_n)
	);

	apfs_clock_divider u_clock_div (
		.clock(clock),
		.sys_rst(sys_rst),
		.stop(usb_suspend),
		.div2(clk_div2),
		.div4(clk_div4),
		.div8(clk_div8)
	);

	// ==========================================
	// aux pin multiplexer

	logic [4*AUX_PINS-1:0] func_flat;
	assign func_flat = {func_hi[4*AUX_PINS-33:0], func_lo};

	for (genvar i = 0; i < AUX_PINS; i++) begin : g_pin
		logic [3:0] raw_code;
		logic [3:0] sel;
		logic next_out;
		logic next_oe;
		logic next_pu;
		logic next_pd;

		assign raw_code = func_flat[4*i +: 4];

		// illegal codes fall back to the pin's default input
		always_comb begin
			if (code_allowed(i, raw_code)) begin
				sel = raw_code;
			end else if (i == apfs_pkg::PULLDOWN_PIN) begin
				sel = apfs_pkg::FN_INPUT_PULLDOWN;
			end else begin
				sel = apfs_pkg::FN_INPUT_PULLUP;
			end
		end

		always_comb begin
			next_out = 1'b0;
			next_oe = 1'b1;
			next_pu = 1'b0;
			next_pd = 1'b0;
			case (sel)
				apfs_pkg::FN_TX_DRIVER_ENABLE: next_out = tx_den;
				apfs_pkg::FN_POWER_SWITCH: next_out = power_switch_n;
				apfs_pkg::FN_TX_LED: next_out = tx_led_n;
				apfs_pkg::FN_RX_LED: next_out = rx_led_n;
				apfs_pkg::FN_TXRX_LED: next_out = txrx_led_n;
				apfs_pkg::FN_SLEEP: next_out = sleep_n;
				apfs_pkg::FN_CLOCK_DIV2: next_out = clk_div2;
				apfs_pkg::FN_CLOCK_DIV4: next_out = clk_div4;
				apfs_pkg::FN_CLOCK_DIV8: next_out = clk_div8;
				apfs_pkg::FN_DRIVE_HIGH: next_out = 1'b1;
				apfs_pkg::FN_DRIVE_LOW: next_out = 1'b0;
				apfs_pkg::FN_BITBANG: begin
					next_out = bitbang[apfs_pkg::BB_DATA_LSB + i];
					next_oe = bitbang[apfs_pkg::BB_DIR_LSB + i];
				end
				apfs_pkg::FN_INPUT_PULLDOWN: begin
					next_oe = 1'b0;
					next_pd = 1'b1;
				end
				default: begin
					next_oe = 1'b0;
					next_pu = 1'b1;
				end
			endcase
		end

		always_ff @(posedge clock) begin
			if (sys_rst || !applied) begin
				aux_pin_out[i] <= 1'b0;
				aux_pin_oe[i] <= 1'b0;
				aux_pullup[i] <= 1'b0;
				aux_pulldown[i] <= 1'b0;
			end else begin
				aux_pin_out[i] <= next_out;
				aux_pin_oe[i] <= next_oe;
				aux_pullup[i] <= next_pu;
				aux_pulldown[i] <= next_pd;
			end
		end
	end

	// ==========================================
	// uart pins

	logic uart_mode;
	logic ring_prev;

	assign uart_mode = ~ctrl[apfs_pkg::CTRL_MODE_BIT];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			primary_pin_out <= '1;
			primary_pin_oe <= 1'b0;
		end else begin
			primary_pin_out <= uart_out;
			primary_pin_oe <= applied & uart_mode;
		end
	end

	assign uart_in = prim_sync;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			serial_pullup <= 1'b1;
			serial_pulldown <= 1'b0;
		end else begin
			serial_pullup <= ~(ctrl[apfs_pkg::CTRL_SUSP_PD_BIT] & usb_suspend);
			serial_pulldown <= ctrl[apfs_pkg::CTRL_SUSP_PD_BIT] & usb_suspend;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ring_prev <= 1'b1;
			resume_request <= 1'b0;
		end else begin
			ring_prev <= prim_sync.ring_indicate_n;
			resume_request <= ctrl[apfs_pkg::CTRL_WAKE_BIT] & usb_suspend &
				ring_prev & ~prim_sync.ring_indicate_n;
		end
	end

endmodule // apfs_aux_pin_function_select

// ### apfs_chk.sv
`timescale 1ns/100ps
module apfs_chk #(
	parameter int unsigned AUX_PINS = apfs_pkg::AUX_PINS
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// bus and usb status
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic resume_request,
	// uart engine and pins
	input wire logic tx_request,
	input wire logic tx_active,
	input wire logic tx_done,
	input wire logic rx_active,
	input wire logic tx_go,
	input wire apfs_pkg::apfs_uart_in_t primary_pin_in,
	input wire logic [AUX_PINS-1:0] aux_pin_out,
	input wire logic [AUX_PINS-1:0] aux_pin_oe,
	input wire logic [AUX_PINS-1:0] aux_pullup
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// shadow of the function codes
	logic [39:0] fn;
	logic [3:0] cnt;
	logic wake;
	wire wr = psel && penable && pwrite;
	// pins only judged once an apply has settled
	wire ok = cnt == 4'h8;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fn <= 40'h99d9999999;
			wake <= 1'h0;
		end else if (wr && paddr == apfs_pkg::ADDR_FUNC_LO) begin
			fn[31:0] <= pwdata;
		end else if (wr && paddr == apfs_pkg::ADDR_FUNC_HI) begin
			fn[39:32] <= pwdata[7:0];
		end else if (wr && paddr == apfs_pkg::ADDR_CTRL) begin
			wake <= pwdata[1];
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst || (wr && paddr[11:3] == 9'h000)) begin
			cnt <= 4'h0;
		end else if (wr && paddr == apfs_pkg::ADDR_CTRL && pwdata[0]) begin
			cnt <= 4'h1;
		end else if (cnt != 4'h0 && !ok) begin
			cnt <= cnt + 4'h1;
		end
	end
	// ==========================================
	// properties
	a_reset_tristate:
	assert property (disable iff (1'h0) sys_rst |=> aux_pin_oe == '0 && aux_pullup == '0)
	else $error("aux pins not released in reset");
	a_den_hold:
	assert property (ok && fn[3:0] == 4'h0 && tx_go |=> aux_pin_out[0] [*3])
	else $error("driver enable dropped in frame");
	a_den_release:
	assert property (ok && fn[3:0] == 4'h0 && tx_done && !tx_request |-> ##2 !aux_pin_out[0])
	else $error("driver enable held after stop bit");
	a_power_off:
	assert property ((ok && fn[7:4] == 4'h1 && usb_suspend) [*4] |-> aux_pin_out[1])
	else $error("power switch on in suspend");
	a_power_on:
	assert property ((ok && fn[7:4] == 4'h1 && usb_configured && !usb_suspend) [*4]
		|-> !aux_pin_out[1]) else $error("power switch off when configured");
	a_sleep_low:
	assert property ((ok && fn[7:4] == 4'h5 && usb_suspend) [*4] |-> !aux_pin_out[1])
	else $error("sleep output high in suspend");
	a_clock_stop:
	assert property ((ok && fn[23:20] == 4'h6 && usb_suspend) [*4] |-> !aux_pin_out[5])
	else $error("clock output runs in suspend");
	a_clock_run:
	assert property ((ok && fn[23:20] == 4'h6 && !usb_suspend) [*4]
		|-> aux_pin_out[5] != $past(aux_pin_out[5])) else $error("half clock not toggling");
	a_tx_led:
	assert property (ok && fn[11:8] == 4'h2 && tx_active |-> ##2 !aux_pin_out[2])
	else $error("tx led dark while sending");
	a_rx_led:
	assert property (ok && fn[15:12] == 4'h3 && rx_active |-> ##2 !aux_pin_out[3])
	else $error("rx led dark while receiving");
	a_txrx_led:
	assert property (ok && fn[19:16] == 4'h4 && (tx_active || rx_active) |-> ##2 !aux_pin_out[4])
	else $error("shared led dark on traffic");
	a_wake_resume:
	assert property (wake && usb_suspend && $fell(primary_pin_in.ring_indicate_n)
		|-> ##[3:5] resume_request) else $error("no resume after ring");
	c_frame: cover property (ok && tx_go);
	c_resume: cover property (resume_request);
	c_sleep: cover property (ok && usb_suspend && fn[7:4] == 4'h5);
endmodule // apfs_chk

// ### apfs_far_side.sv
`timescale 1ns/100ps
module apfs_far_side (
	// clock
	input wire logic clock,
	// bench commands
	input wire logic line_rx,
	input wire logic ring_on,
	// device pins
	input wire logic [9:0] aux_pin_out,
	input wire logic [9:0] aux_pin_oe,
	input wire logic [9:0] aux_pullup,
	input wire logic [9:0] aux_pulldown,
	output apfs_pkg::apfs_uart_in_t primary_pin_in,
	output logic [9:0] aux_pin_in
);
	// ==========================================
	// transceiver lines and aux wires
	logic flip = 1'h0;
	// a floating wire wanders, so a stale level cannot pass
	always @(posedge clock) begin
		flip <= !flip;
	end
	always_comb begin
		primary_pin_in = {line_rx, 3'h0, !ring_on};
		for (int i = 0; i < 10; i++) begin
			aux_pin_in[i] = aux_pin_oe[i] ? aux_pin_out[i] : aux_pullup[i] | (!aux_pulldown[i] & flip);
		end
	end
endmodule // apfs_far_side

// ### tb_aux_pin_function_select.sv
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("ERROR %s expected %h seen %h", nm, exp, got); \
	end \
end
module tb_aux_pin_function_select;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, e_v, m_v;
	logic pready, pslverr, resume_request, tx_go, primary_pin_oe, serial_pullup, serial_pulldown, b;
	logic usb_configured = 1'h0, usb_suspend = 1'h0, config_memory_present = 1'h0;
	logic tx_request = 1'h0, bit_tick = 1'h0, tx_active = 1'h0, tx_done = 1'h0, rx_active = 1'h0;
	logic line_rx = 1'h1, ring_on = 1'h0;
	logic [2:0] tick_cnt = 3'h0;
	apfs_pkg::apfs_uart_out_t uart_out = 3'h7, primary_pin_out;
	apfs_pkg::apfs_uart_in_t uart_in, primary_pin_in;
	logic [9:0] aux_pin_in, aux_pin_out, aux_pin_oe, aux_pullup, aux_pulldown;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int n_fail = 0, cmp_count = 0, seed, cyc = 0, pulses;
	apfs_aux_pin_function_select #(.LED_HOLD_CYCLES(4)) dut_u (.*);
	apfs_far_side far_u (.clock(clock), .line_rx(line_rx), .ring_on(ring_on),
		.aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe), .aux_pullup(aux_pullup),
		.aux_pulldown(aux_pulldown), .primary_pin_in(primary_pin_in), .aux_pin_in(aux_pin_in));
	always #20 clock = !clock;
	// ==========================================
	// uart engine bit timing and watchdog
	always @(posedge clock) begin
		tick_cnt <= tick_cnt + 3'h1;
		bit_tick <= tick_cnt == 3'h7;
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	// read results checked against the oldest note
	always @(posedge clock) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			`CHK("read data", prdata & m_v, e_v)
			`CHK("slave error", pslverr, paddr > apfs_pkg::ADDR_STATUS)
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(m);
		apb(1'h0, a, 32'h0);
	endtask
	// one frame, requested just after a tick
	task automatic frame();
		do @(posedge clock); while (bit_tick !== 1'h1);
		tx_request <= 1'h1;
		pulses = 0;
		do begin
			@(posedge clock);
			pulses += aux_pin_out[0];
		end while (tx_go !== 1'h1);
		`CHK("den at start", aux_pin_out[0], 1'h1)
		// eight-cycle bit, less the one-flop lag of enable behind the unregistered tx_go
		`CHK("den lead", pulses, 7)
		tx_request <= 1'h0;
		tx_active <= 1'h1;
		repeat (10) do @(posedge clock); while (bit_tick !== 1'h1);
		`CHK("leds in frame", {aux_pin_out[4], aux_pin_out[2], aux_pin_out[0]}, 3'h1)
		tx_active <= 1'h0;
		tx_done <= 1'h1;
		@(posedge clock);
		tx_done <= 1'h0;
		wt(3);
		`CHK("den after stop", aux_pin_out[0], 1'h0)
	endtask
	// ==========================================
	// main sequence
	initial begin
		seed = 18786;
		wt(8);
		`CHK("pins in reset", {aux_pin_oe, aux_pullup}, 20'h00000)
		wt(8);
		sys_rst <= 1'h0;
		wt(4);
		`CHK("default pulls", {aux_pullup, aux_pulldown, aux_pin_oe}, {10'h37f, 10'h080, 10'h000})
		rd(apfs_pkg::ADDR_FUNC_LO, 32'hffffffff, 32'hd9999999);
		rd(apfs_pkg::ADDR_STATUS, 32'h03ff0000, 32'h037f0000);
		rd(12'h020, 32'hffffffff, 32'h00000000);
		usb_configured <= 1'h1;
		uart_out <= 3'($random(seed));
		line_rx <= 1'($random(seed));
		apb(1'h1, apfs_pkg::ADDR_FUNC_LO, 32'hd7643210);
		apb(1'h1, apfs_pkg::ADDR_FUNC_HI, 32'h000000a8);
		apb(1'h1, apfs_pkg::ADDR_CTRL, 32'h00000003);
		wt(4);
		`CHK("driven pins", {aux_pin_oe, aux_pin_out[1]}, {10'h37f, 1'h0})
		`CHK("uart drive", {primary_pin_oe, primary_pin_out}, {1'h1, uart_out})
		`CHK("uart sample", uart_in, {line_rx, 4'h1})
		b = aux_pin_out[5];
		@(posedge clock);
		`CHK("half clock", aux_pin_out[5], !b)
		frame();
		wt(20);
		`CHK("tx led idle", aux_pin_out[2], 1'h1)
		rx_active <= 1'h1;
		wt(3);
		`CHK("leds on receive", aux_pin_out[4:2], 3'h1)
		rx_active <= 1'h0;
		usb_suspend <= 1'h1;
		wt(6);
		`CHK("suspended", {aux_pin_out[1], aux_pin_out[5], aux_pin_out[6], aux_pin_out[8]}, 4'h8)
		`CHK("serial pulls", {serial_pullup, serial_pulldown}, 2'h2)
		ring_on <= 1'h1;
		pulses = 0;
		repeat (8) begin
			@(posedge clock);
			pulses += resume_request;
		end
		`CHK("resume pulses", pulses, 1)
		ring_on <= 1'h0;
		usb_suspend <= 1'h0;
		apb(1'h1, apfs_pkg::ADDR_FUNC_LO, 32'hd7643b50);
		apb(1'h1, apfs_pkg::ADDR_FUNC_HI, 32'h000000c8);
		apb(1'h1, apfs_pkg::ADDR_BITBANG, 32'h02000200);
		apb(1'h1, apfs_pkg::ADDR_CTRL, 32'h0000000d);
		wt(4);
		`CHK("awake levels", {aux_pin_out[9], aux_pin_out[2:1]}, 3'h5)
		`CHK("other mode", primary_pin_oe, 1'h0)
		usb_suspend <= 1'h1;
		wt(6);
		`CHK("sleep low", aux_pin_out[1], 1'h0)
		`CHK("suspend pulls", {serial_pullup, serial_pulldown}, 2'h1)
		usb_suspend <= 1'h0;
		wt(4);
		// second reset with the strap present: pins wait for apply
		config_memory_present <= 1'h1;
		sys_rst <= 1'h1;
		wt(4);
		sys_rst <= 1'h0;
		wt(4);
		`CHK("unapplied pins", {aux_pin_oe, aux_pullup, aux_pulldown, primary_pin_oe}, 31'h0)
		rd(apfs_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
		apb(1'h1, apfs_pkg::ADDR_CTRL, 32'h00000001);
		wt(4);
		`CHK("applied pulls", {aux_pullup, aux_pulldown, aux_pin_oe}, {10'h37f, 10'h080, 10'h000})
		rd(apfs_pkg::ADDR_STATUS, 32'h00000001, 32'h00000001);
		give_verdict();
	end
endmodule // tb_aux_pin_function_select
bind apfs_aux_pin_function_select apfs_chk #(.AUX_PINS(AUX_PINS)) chk_u (.*);
